// >>> rtl/psw_ctrl.sv
// terminal shutdown and wiper latch control
// Functional notes
// RQ1 - shutdown pin low: A open, W to B
// RQ2 - pin shutdown ignores but keeps terminal bits
// RQ3 - pin shutdown keeps wiper register value
// RQ4 - serial commands execute during shutdown
// RQ5 - terminal bits never touch wiper register
// RQ6 - four bits: A, W, B, software shutdown
// RQ7 - software shutdown ignores, keeps connect bits
// RQ8 - latch high blocks register to wiper
// RQ9 - wiper follows register while latch low
// RQ10 - host ties latch low if unused
// RQ11 - latch gates only the wiper transfer
// RQ12 - wiper value transferred coherently
// RQ13 - power-on reset forces register defaults
// RQ14 - brownout ignores serial, forces terminal state
// RQ15 - wiper register defaults to mid-scale
// RQ16 - shutdown is pin or software bit
// RQ17 - outside shutdown, each pin follows bit
`timescale 1ns/1ps
module psw_ctrl
  import psw_pkg::*;
#(
  parameter int WIPER_W = `PSW_WIPER_W,
  parameter logic [WIPER_W-1:0] WIPER_MID = `PSW_WIPER_MID
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic hw_shutdown_n_i,
  input wire logic wiper_update_hold_i,
  input wire logic digital_brownout_i,
  input wire logic wiper_wr_i,
  input wire logic [WIPER_W-1:0] wiper_wdata_i,
  input wire logic terminal_ctrl_reg_wr_i,
  input wire logic [`PSW_TERMINAL_CTRL_REG_W-1:0] terminal_ctrl_reg_wdata_i,
  output logic [WIPER_W-1:0] wiper_reg_o,
  output logic [`PSW_TERMINAL_CTRL_REG_W-1:0] terminal_ctrl_reg_reg_o,
  output logic [WIPER_W-1:0] wiper_pos_o,
  output psw_term_type term_o,
  output logic shutdown_o,
  output logic cmd_ignored_o
);
  logic [1:0] pins_sync;
  logic hw_shutdown_n_n_s;
  logic hold_s;
  logic bor_s;
  logic [WIPER_W-1:0] wiper_reg, wiper_next;
  psw_terminal_ctrl_reg_type terminal_ctrl_reg, terminal_ctrl_next;
  logic [WIPER_W-1:0] pos_reg, pos_next;
  psw_term_type term_reg, term_next;
  logic shut_reg, shut_next;
  logic ign_reg, ign_next;
  logic bor_pipe_reg;

  psw_sync #(.WIDTH(2), .RST_VAL(2'h1)) u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .async_i({wiper_update_hold_i, hw_shutdown_n_i}),
    .sync_o(pins_sync)
  );
  assign hw_shutdown_n_n_s = pins_sync[0];
  assign hold_s = pins_sync[1];

  // brownout is an asynchronous level; run it through its own pair
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bor_pipe_reg <= 1'b1;
      bor_s <= 1'b1;
    end else begin
      bor_pipe_reg <= digital_brownout_i;
      bor_s <= bor_pipe_reg;
    end
  end

  function automatic psw_terminal_ctrl_reg_type unpack_terminal_ctrl_reg(input logic [`PSW_TERMINAL_CTRL_REG_W-1:0] v);
    psw_terminal_ctrl_reg_type t;
    t.sw_shutdown_select = v[`PSW_TERMINAL_CTRL_REG_HW_POS];
    t.term_a_connect = v[`PSW_TERMINAL_CTRL_REG_A_POS];
    t.term_w_connect = v[`PSW_TERMINAL_CTRL_REG_W_POS];
    t.term_b_connect = v[`PSW_TERMINAL_CTRL_REG_B_POS];
    return t;
  endfunction : unpack_terminal_ctrl_reg

  // register file: writes accepted regardless of shutdown or latch
  always_comb begin
    wiper_next = wiper_reg;
    terminal_ctrl_next = terminal_ctrl_reg;
    ign_next = 1'b0;
    if (bor_s) begin
      wiper_next = WIPER_MID; // [RQ14] [RQ15]
      terminal_ctrl_next = unpack_terminal_ctrl_reg(`PSW_TERMINAL_CTRL_REG_RST); // [RQ13]
      ign_next = wiper_wr_i | terminal_ctrl_reg_wr_i; // [RQ14]
    end else begin
      if (wiper_wr_i) begin
        wiper_next = wiper_wdata_i; // [RQ4] [RQ11]
      end
      if (terminal_ctrl_reg_wr_i) begin
        terminal_ctrl_next = unpack_terminal_ctrl_reg(terminal_ctrl_reg_wdata_i); // [RQ4] [RQ5] [RQ6]
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wiper_reg <= WIPER_MID; // [RQ13] [RQ15]
      terminal_ctrl_reg <= `PSW_TERMINAL_CTRL_REG_RST; // [RQ13]
      ign_reg <= 1'b0;
    end else begin
      wiper_reg <= wiper_next;
      terminal_ctrl_reg <= terminal_ctrl_next;
      ign_reg <= ign_next;
    end
  end

  // wiper transfer and terminal switching
  always_comb begin
    pos_next = pos_reg;
    shut_next = ~hw_shutdown_n_n_s | terminal_ctrl_reg.sw_shutdown_select; // [RQ16]
    if (bor_s) begin
      pos_next = WIPER_MID; // [RQ14]
    end else if (!hold_s) begin
      // copy of the whole settled register word, never a partial load
      pos_next = wiper_reg; // [RQ8] [RQ9] [RQ12] [RQ3]
    end
    if (shut_next) begin
      term_next.term_a_pin = 1'b0; // [RQ1] [RQ7]
      term_next.term_w_pin = 1'b1; // [RQ1]
      term_next.term_b_pin = 1'b1; // [RQ1]
      term_next.w_to_b_short = 1'b1; // [RQ1] [RQ2]
    end else begin
      term_next.term_a_pin = terminal_ctrl_reg.term_a_connect; // [RQ17] [RQ2]
      term_next.term_w_pin = terminal_ctrl_reg.term_w_connect; // [RQ17]
      term_next.term_b_pin = terminal_ctrl_reg.term_b_connect; // [RQ17]
      term_next.w_to_b_short = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pos_reg <= WIPER_MID;
      term_reg <= '0;
      shut_reg <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      term_reg <= term_next;
      shut_reg <= shut_next;
    end
  end

  assign wiper_reg_o = wiper_reg;
  assign terminal_ctrl_reg_reg_o = terminal_ctrl_reg;
  assign wiper_pos_o = pos_reg;
  assign term_o = term_reg;
  assign shutdown_o = shut_reg;
  assign cmd_ignored_o = ign_reg;
endmodule : psw_ctrl

// >>> include/psw_defines.svh
// constants for the shutdown and wiper latch control block
`ifndef PSW_DEFINES_SVH
`define PSW_DEFINES_SVH
`define PSW_WIPER_W 8
`define PSW_WIPER_MID 8'h7f
`define PSW_TERMINAL_CTRL_REG_W 4
`define PSW_TERMINAL_CTRL_REG_B_POS 0
`define PSW_TERMINAL_CTRL_REG_W_POS 1
`define PSW_TERMINAL_CTRL_REG_A_POS 2
`define PSW_TERMINAL_CTRL_REG_HW_POS 3
`define PSW_TERMINAL_CTRL_REG_RST 4'hf
`endif

// >>> include/psw_pkg.sv
// types for the shutdown and wiper latch control block
`include "psw_defines.svh"
package psw_pkg;
  typedef struct packed {
    logic sw_shutdown_select;
    logic term_a_connect;
    logic term_w_connect;
    logic term_b_connect;
  } psw_terminal_ctrl_reg_type;
  typedef struct packed {
    logic term_a_pin;
    logic term_w_pin;
    logic term_b_pin;
    logic w_to_b_short;
  } psw_term_type;
  typedef struct packed {
    logic wiper_wr;
    logic terminal_ctrl_reg_wr;
    logic [`PSW_WIPER_W-1:0] wdata;
  } psw_cmd_type;
endpackage : psw_pkg

// >>> rtl/psw_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module psw_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end
  assign sync_o = sync_reg;
endmodule : psw_sync

// >>> sim/psw_ctrl_asserts.sv
// checker for the shutdown and wiper latch control
`timescale 1ns/1ps
module psw_ctrl_asserts import psw_pkg::*; (
  input logic ref_clk_i, arst_n_i, hw_shutdown_n_i, wiper_update_hold_i,
  input logic digital_brownout_i, wiper_wr_i, terminal_ctrl_reg_wr_i, shutdown_o, cmd_ignored_o,
  input logic [7:0] wiper_wdata_i, wiper_reg_o, wiper_pos_o,
  input logic [3:0] terminal_ctrl_reg_reg_o,
  input psw_term_type term_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_pin_shutdown: assert property ((!hw_shutdown_n_i)[*4] |-> shutdown_o)
    else $error("pin shutdown missing");
  a_sd_config: assert property (shutdown_o |-> term_o == 4'h7)
    else $error("shutdown terminals wrong");
  a_term_follow: assert property ($past(arst_n_i) && !shutdown_o && $stable(terminal_ctrl_reg_reg_o)
    |-> term_o == {terminal_ctrl_reg_reg_o[2:0], 1'b0}) else $error("terminals not following bits");
  a_wiper_take: assert property ((!digital_brownout_i)[*3] ##0 wiper_wr_i
    |=> wiper_reg_o == $past(wiper_wdata_i)) else $error("wiper write lost");
  a_terminal_ctrl_reg_keep: assert property ($changed(terminal_ctrl_reg_reg_o)
    |-> $past(terminal_ctrl_reg_wr_i) || $past(digital_brownout_i, 3)) else $error("bits changed");
  a_wiper_keep: assert property (!$past(wiper_wr_i) && !$past(digital_brownout_i, 3)
    |-> $stable(wiper_reg_o)) else $error("wiper register changed");
  a_hold_block: assert property (wiper_update_hold_i[*4] |=> $stable(wiper_pos_o))
    else $error("wiper moved while held");
  a_pos_follow: assert property ((!wiper_update_hold_i && !digital_brownout_i)[*4]
    |-> wiper_pos_o == $past(wiper_reg_o)) else $error("wiper not following");
  a_ign_pulse: assert property (digital_brownout_i[*3] ##0 (wiper_wr_i || terminal_ctrl_reg_wr_i)
    |=> cmd_ignored_o) else $error("ignored write not flagged");
  a_bor_default: assert property (digital_brownout_i[*4]
    |-> wiper_reg_o == 8'h7f && terminal_ctrl_reg_reg_o == 4'hf) else $error("defaults not forced");
endmodule : psw_ctrl_asserts
bind psw_ctrl psw_ctrl_asserts i_psw_ctrl_asserts (.*);

// >>> sim/psw_host.sv
// host model driving the control pins and register writes
`timescale 1ns/1ps
module psw_host import psw_pkg::*; (
  input wire logic ref_clk_i,
  output psw_cmd_type cmd_o,
  output logic [3:0] terminal_ctrl_reg_o,
  output logic sd_n_o, hold_o, bor_o
);
  initial {cmd_o, terminal_ctrl_reg_o, sd_n_o, hold_o, bor_o} = {14'h0, 3'h4};
  task automatic wr(input logic w, t, input logic [7:0] d);
    @(posedge ref_clk_i);
    cmd_o <= '{w, t, d};
    terminal_ctrl_reg_o <= d[3:0];
    @(posedge ref_clk_i);
    cmd_o <= '0;
  endtask : wr
  task automatic pins(input logic s, h, b);
    @(posedge ref_clk_i);
    {sd_n_o, hold_o, bor_o} <= {s, h, b};
  endtask : pins
endmodule : psw_host

// >>> sim/pot_shutdown_wiper_latch_tb.sv
// self-checking bench for the shutdown and wiper latch control
`timescale 1ns/1ps
module pot_shutdown_wiper_latch_tb import psw_pkg::*;;
  logic ref_clk_i = 1'b0, arst_n_i = 1'b0, hw_shutdown_n_i, wiper_update_hold_i;
  logic digital_brownout_i, shutdown_o, cmd_ignored_o;
  logic [7:0] wiper_reg_o, wiper_pos_o, ep, er, d;
  logic [3:0] terminal_ctrl_reg_wdata_i, terminal_ctrl_reg_reg_o;
  psw_term_type term_o;
  psw_cmd_type cmd;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  wire logic wiper_wr_i = cmd.wiper_wr;
  wire logic terminal_ctrl_reg_wr_i = cmd.terminal_ctrl_reg_wr;
  wire logic [7:0] wiper_wdata_i = cmd.wdata;
  always #2.5 ref_clk_i = ~ref_clk_i;
  psw_host i_psw_host (.ref_clk_i, .cmd_o(cmd), .terminal_ctrl_reg_o(terminal_ctrl_reg_wdata_i),
    .sd_n_o(hw_shutdown_n_i), .hold_o(wiper_update_hold_i), .bor_o(digital_brownout_i));
  psw_ctrl i_psw_ctrl (.*);
  function automatic psw_term_type exp_term(input logic s, input logic [3:0] t);
    return (!s || t[3]) ? 4'h7 : {t[2:0], 1'b0};
  endfunction : exp_term
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : w
  task automatic chk(input string n, input logic [7:0] e, s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk_i) if (++cyc == 3000) begin
    miscompares++;
    report_and_stop();
  end
  initial begin
    void'($urandom(52776));
    repeat (3) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    w(3);
    chk("wreg", 8'h7f, wiper_reg_o);
    chk("treg", 8'h0f, {4'h0, terminal_ctrl_reg_reg_o});
    for (int i = 0; i < 32; i++) begin
      i_psw_host.wr(1'b0, 1'b1, {4'h0, i[3:0]});
      i_psw_host.pins(i[4], 1'b0, 1'b0);
      w(4);
      chk("term", {4'h0, exp_term(i[4], i[3:0])}, {4'h0, term_o});
      chk("treg", {4'h0, i[3:0]}, {4'h0, terminal_ctrl_reg_reg_o});
      chk("pos", 8'h7f, wiper_pos_o);
      chk("sd", {7'h0, !i[4] || i[3]}, {7'h0, shutdown_o});
    end
    i_psw_host.pins(1'b1, 1'b0, 1'b1);
    w(3);
    i_psw_host.wr(1'b1, 1'b0, 8'h12);
    w(0);
    chk("ign", 8'h01, {7'h0, cmd_ignored_o});
    i_psw_host.pins(1'b1, 1'b0, 1'b0);
    w(4);
    chk("wreg", 8'h7f, wiper_reg_o);
    chk("treg", 8'h0f, {4'h0, terminal_ctrl_reg_reg_o});
    {er, ep} = 16'h7f7f;
    for (int i = 0; i < 40; i++) begin
      d = 8'($urandom);
      i_psw_host.pins(1'($urandom), 1'($urandom), 1'b0);
      w(3);
      if (!wiper_update_hold_i) ep = er;
      i_psw_host.wr(1'b1, 1'b0, d);
      w(1);
      er = d;
      if (!wiper_update_hold_i) ep = d;
      chk("wreg", er, wiper_reg_o);
      chk("pos", ep, wiper_pos_o);
      chk("ign", 8'h00, {7'h0, cmd_ignored_o});
    end
    report_and_stop();
  end
endmodule : pot_shutdown_wiper_latch_tb
